// >>> src/fgscp_consts.vh
// Function
// R01: host pulls frame_latch_enable low before any read or write frame starts.
// R02: first serial clock rise after latch falls samples data: one writes, zero reads.
// R03: write frame takes 15 more bits on 15 rises, LSB first, 16 in all.
// R04: latch rising after a write ends it and applies the new code at once.
// R05: read frame shifts stored 15 bits out on 15 falling edges, LSB first.
// R06: latch rising ends a read; reading never changes the stored word.
// R07: stored word holds 6-bit filter code: 1 to 63 MHz corner, or bypass.
// R08: post-filter fixed gain field picks 12, 15, 18 or 21 dB.
// R09: one stored bit turns the output offset correction loop on or off.
// R10: stored word also holds the power mode selection.
// R11: filter, all gains and buffer gain update together from one stored word.
// R12: a stored field selects the output buffer gain, low or high setting.
// R13: host high pulse of 25 ns or more outside reads clears peak hold.
// R14: host changes data only while serial clock is low.
`ifndef FGSCP_CONSTS_VH
`define FGSCP_CONSTS_VH

`define FGSCP_CLK_PERIOD_NS   10
`define FGSCP_PEAK_CLR_MIN_NS 25
`define FGSCP_PEAK_CLR_CYC    ((`FGSCP_PEAK_CLR_MIN_NS + `FGSCP_CLK_PERIOD_NS - 1) / `FGSCP_CLK_PERIOD_NS)

`define FGSCP_DATA_BITS       15
`define FGSCP_CFG_RST         15'h0800

`define FGSCP_FILT_LSB        0
`define FGSCP_FILT_BYPASS     6'h00
`define FGSCP_PRE_GAIN_LSB    6
`define FGSCP_POST_GAIN_LSB   8
`define FGSCP_BUF_GAIN_BIT    10
`define FGSCP_DCLOOP_BIT      11
`define FGSCP_PWR_LSB         12

`define FGSCP_ADR_CFG         4'h0
`define FGSCP_ADR_CTRL        4'h4
`define FGSCP_ADR_STAT        4'h8
`define FGSCP_CTRL_RST        2'h1
`define FGSCP_CTRL_EN_BIT     0
`define FGSCP_CTRL_PKCLR_BIT  1

`endif

// >>> src/fgscp_sync.v
`timescale 1ns/1ps
module fgscp_sync #(
   parameter W = 1
) (
   input  wire         clk,   // system clock
   input  wire         rstn,  // async reset, active low
   input  wire [W-1:0] d,     // asynchronous inputs
   output reg  [W-1:0] q      // synchronised outputs
);
   reg [W-1:0] meta_r;

   // meta_r feeds only q
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_r <= {W{1'b0}};
         q      <= {W{1'b0}};
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// >>> src/fgscp_pulse_meas.v
`timescale 1ns/1ps
module fgscp_pulse_meas #(
   parameter MIN_CYC = 3
) (
   input  wire clk,    // system clock
   input  wire rstn,   // async reset, active low
   input  wire level,  // qualified clear level
   output reg  pulse   // one-cycle clear pulse
);
   reg [7:0] cnt_r;

   // one pulse per high period, once the width is proven
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 8'h00;
         pulse <= 1'b0;
      end else begin
         pulse <= 1'b0;
         if (!level) begin
            cnt_r <= 8'h00;
         end else if (cnt_r != 8'hFF) begin
            cnt_r <= cnt_r + 8'h01;
            if (cnt_r == MIN_CYC[7:0] - 8'h01)
               pulse <= 1'b1; // R13
         end
      end
   end
endmodule

// >>> src/fgscp_top.v
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "fgscp_consts.vh"
module fgscp_top (
   input  wire        clk,                     // 100 MHz system clock
   input  wire        rstn,                    // async reset, active low
   input  wire        wb_cyc_i,                // wishbone cycle
   input  wire        wb_stb_i,                // wishbone strobe
   input  wire        wb_we_i,                 // wishbone write enable
   input  wire [3:0]  wb_adr_i,                // wishbone byte address
   input  wire [3:0]  wb_sel_i,                // wishbone byte selects
   input  wire [31:0] wb_dat_i,                // wishbone write data
   output reg  [31:0] wb_dat_o,                // wishbone read data
   output reg         wb_ack_o,                // wishbone acknowledge
   input  wire        frame_latch_enable,      // latch pin, frame while low
   input  wire        serial_clk,              // serial clock pin
   input  wire        serial_data,             // serial data pin
   input  wire        serial_out_peak_clear_i, // shared pin, input level
   output reg         serial_out_peak_clear_o, // shared pin, driven level
   output reg         serial_out_peak_clear_oe,// shared pin, drive enable
   output reg  [5:0]  filt_code_o,             // filter corner code, MHz
   output reg         filt_bypass_o,           // filter bypassed
   output reg  [1:0]  pre_gain_o,              // input stage gain code
   output reg  [1:0]  post_gain_o,             // post-filter gain code
   output reg         buf_gain_hi_o,           // output buffer high gain
   output reg         dc_loop_en_o,            // offset loop enabled
   output reg  [1:0]  pwr_mode_o,              // power mode code
   output wire        peak_clear_o             // peak hold clear pulse
);
   localparam ST_IDLE = 2'b00;
   localparam ST_FLAG = 2'b01;
   localparam ST_WR   = 2'b10;
   localparam ST_RD   = 2'b11;
   localparam NB      = `FGSCP_DATA_BITS;

   function [7:0] sat_inc;
      input [7:0] v;
      begin
         sat_inc = (v == 8'hFF) ? v : v + 8'h01;
      end
   endfunction

   // pins, each through two flops
   wire [3:0] pin_s;
   fgscp_sync #(.W(4)) u_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    ({serial_out_peak_clear_i, serial_data, serial_clk, ~frame_latch_enable}),
      .q    (pin_s)
   );
   wire le_s   = ~pin_s[0]; // carried inverted so reset reads the idle high level
   wire sclk_s = pin_s[1];
   wire sdi_s  = pin_s[2];
   wire pk_s   = pin_s[3];

   reg  sclk_d_r;
   reg  le_d_r;
   wire sclk_rise = sclk_s & ~sclk_d_r;
   wire sclk_fall = ~sclk_s & sclk_d_r;
   wire le_fall   = ~le_s & le_d_r;
   wire le_rise   = le_s & ~le_d_r;

   reg  [1:0]    st_r;
   reg  [1:0]    st_nxt;
   reg  [NB-1:0] wr_sh_r;
   reg  [4:0]    wr_cnt_r;
   reg  [NB-1:0] rd_sh_r;
   reg  [3:0]    rd_cnt_r;
   reg  [NB-1:0] cfg_r;
   reg  [1:0]    ctrl_r;
   reg           sw_pk_r;
   reg  [7:0]    wr_ok_r;
   reg  [7:0]    wr_bad_r;
   reg  [7:0]    rd_done_r;

   wire port_en = ctrl_r[`FGSCP_CTRL_EN_BIT];
   wire wr_full = (wr_cnt_r == NB[4:0]);

   // frame sequencer
   always @* begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE: begin
            if (le_fall && port_en)
               st_nxt = ST_FLAG; // R01
         end
         ST_FLAG: begin
            if (le_s)
               st_nxt = ST_IDLE;
            else if (sclk_rise)
               st_nxt = sdi_s ? ST_WR : ST_RD; // R02
         end
         ST_WR: begin
            if (le_s)
               st_nxt = ST_IDLE; // R04
         end
         ST_RD: begin
            if (le_s)
               st_nxt = ST_IDLE; // R06
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r     <= ST_IDLE;
         sclk_d_r <= 1'b0;
         le_d_r   <= 1'b1;
      end else begin
         st_r     <= st_nxt;
         sclk_d_r <= sclk_s;
         le_d_r   <= le_s;
      end
   end

   // write capture; a short frame or one of 16 to 31 data bits is dropped, never half-applied
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_sh_r  <= {NB{1'b0}};
         wr_cnt_r <= 5'h00;
      end else if (st_r == ST_FLAG) begin
         wr_cnt_r <= 5'h00;
      end else if (st_r == ST_WR && !le_s && sclk_rise) begin
         if (!wr_full) begin
            wr_sh_r  <= {sdi_s, wr_sh_r[NB-1:1]}; // R03
            wr_cnt_r <= wr_cnt_r + 5'h01;
         end else begin
            // overflow code differs from the full count, so a frame of 16 to 31 data bits is dropped; the next rise wraps it to zero
            wr_cnt_r <= 5'h1F;
         end
      end
   end

   // stored word moves in one edge; its decoded fields all follow one edge later
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_r <= `FGSCP_CFG_RST;
      end else if (st_r == ST_WR && le_rise && wr_full) begin
         cfg_r <= wr_sh_r; // R04
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         filt_code_o   <= 6'h00;
         filt_bypass_o <= 1'b0;
         pre_gain_o    <= 2'h0;
         post_gain_o   <= 2'h0;
         buf_gain_hi_o <= 1'b0;
         dc_loop_en_o  <= 1'b0;
         pwr_mode_o    <= 2'h0;
      end else begin
         filt_code_o   <= cfg_r[`FGSCP_FILT_LSB +: 6]; // R11
         filt_bypass_o <= (cfg_r[`FGSCP_FILT_LSB +: 6] == `FGSCP_FILT_BYPASS); // R07
         pre_gain_o    <= cfg_r[`FGSCP_PRE_GAIN_LSB +: 2];
         post_gain_o   <= cfg_r[`FGSCP_POST_GAIN_LSB +: 2]; // R08
         buf_gain_hi_o <= cfg_r[`FGSCP_BUF_GAIN_BIT]; // R12
         dc_loop_en_o  <= cfg_r[`FGSCP_DCLOOP_BIT]; // R09
         pwr_mode_o    <= cfg_r[`FGSCP_PWR_LSB +: 2]; // R10
      end
   end

   // readback: a copy is shifted, cfg_r is untouched
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_sh_r                  <= {NB{1'b0}};
         rd_cnt_r                 <= 4'h0;
         serial_out_peak_clear_o  <= 1'b0;
         serial_out_peak_clear_oe <= 1'b0;
      end else if (st_r == ST_FLAG) begin
         rd_sh_r  <= cfg_r; // R06
         rd_cnt_r <= 4'h0;
      end else if (st_r == ST_RD && !le_s) begin
         if (sclk_fall && rd_cnt_r != NB[3:0]) begin
            serial_out_peak_clear_o  <= rd_sh_r[0]; // R05
            serial_out_peak_clear_oe <= 1'b1;
            rd_sh_r  <= {1'b0, rd_sh_r[NB-1:1]};
            rd_cnt_r <= rd_cnt_r + 4'h1;
         end
      end else begin
         serial_out_peak_clear_o  <= 1'b0;
         serial_out_peak_clear_oe <= 1'b0;
      end
   end

   // shared pin only counts as a clear while nobody reads; a frame whose
   // direction is not yet known counts as a read
   wire      pk_busy = (st_r == ST_FLAG) | (st_r == ST_RD) | serial_out_peak_clear_oe;
   reg [2:0] pk_hold_r;

   // synced pin lags the drive enable, so the block outlasts the read
   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         pk_hold_r <= 3'h0;
      else
         pk_hold_r <= {pk_hold_r[1:0], pk_busy};
   end

   wire pk_level = pk_s & ~pk_busy & ~(|pk_hold_r); // R13
   wire hw_pk;

   fgscp_pulse_meas #(.MIN_CYC(`FGSCP_PEAK_CLR_CYC)) u_pk (
      .clk   (clk),
      .rstn  (rstn),
      .level (pk_level),
      .pulse (hw_pk)
   );

   reg pk_out_r;
   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         pk_out_r <= 1'b0;
      else
         pk_out_r <= hw_pk | sw_pk_r; // R13
   end
   assign peak_clear_o = pk_out_r;

   // frame statistics
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ok_r   <= 8'h00;
         wr_bad_r  <= 8'h00;
         rd_done_r <= 8'h00;
      end else if (le_rise) begin
         if (st_r == ST_WR && wr_full)
            wr_ok_r <= sat_inc(wr_ok_r);
         else if (st_r == ST_WR)
            wr_bad_r <= sat_inc(wr_bad_r);
         else if (st_r == ST_RD)
            rd_done_r <= sat_inc(rd_done_r);
      end
   end

   // wishbone slave, one wait state, unmapped reads zero
   wire wb_req = wb_cyc_i & wb_stb_i;
   wire wb_wr  = wb_req & wb_ack_o & wb_we_i & wb_sel_i[0];

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req & ~wb_ack_o;
         wb_dat_o <= 32'h0000_0000;
         if (wb_req && !wb_ack_o && !wb_we_i) begin
            case (wb_adr_i)
               `FGSCP_ADR_CFG:  wb_dat_o <= {17'h00000, cfg_r};
               `FGSCP_ADR_CTRL: wb_dat_o <= {30'h00000000, 1'b0, ctrl_r[0]};
               `FGSCP_ADR_STAT: wb_dat_o <= {rd_done_r, wr_bad_r, wr_ok_r,
                                             4'h0, wr_cnt_r[1:0], st_r};
               default:         wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // clear bit self-clears; it never holds the clear line
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r  <= `FGSCP_CTRL_RST;
         sw_pk_r <= 1'b0;
      end else begin
         sw_pk_r <= 1'b0;
         if (wb_wr && wb_adr_i == `FGSCP_ADR_CTRL) begin
            ctrl_r[`FGSCP_CTRL_EN_BIT] <= wb_dat_i[`FGSCP_CTRL_EN_BIT];
            sw_pk_r                    <= wb_dat_i[`FGSCP_CTRL_PKCLR_BIT];
         end
      end
   end
endmodule

// >>> sim/fgscp_top_asserts.sv
`timescale 1ns/1ps
module fgscp_top_chk (
   input wire        clk,                      // system clock
   input wire        rstn,                     // async reset, active low
   input wire        wb_cyc_i,                 // bus cycle
   input wire        wb_stb_i,                 // bus strobe
   input wire [31:0] wb_dat_o,                 // read data
   input wire        wb_ack_o,                 // acknowledge
   input wire        frame_latch_enable,       // latch pin
   input wire        serial_out_peak_clear_oe, // readback drive enable
   input wire [5:0]  filt_code_o,              // filter code
   input wire        filt_bypass_o,            // filter bypass
   input wire [1:0]  post_gain_o,              // post gain code
   input wire        dc_loop_en_o,             // offset loop enable
   input wire [1:0]  pwr_mode_o,               // power mode
   input wire        peak_clear_o              // peak clear pulse
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);
   sequence wb_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // apply lands within 5 clk of latch rise, so 6 low cycles are quiet
   sequence latch_held;
      !frame_latch_enable [*6];
   endsequence
   wb_ack_once_a: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle after request");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   cfg_hold_a: assert property (
      latch_held |-> $stable({filt_code_o, post_gain_o, dc_loop_en_o, pwr_mode_o}))
      else $error("config changed inside a frame");
   oe_in_frame_a: assert property ($rose(serial_out_peak_clear_oe) |-> !frame_latch_enable)
      else $error("readback drive outside a frame");
   oe_release_a: assert property (
      $rose(frame_latch_enable) |-> ##[1:8] !serial_out_peak_clear_oe)
      else $error("readback drive kept after latch rise");
   bypass_code_a: assert property (filt_bypass_o |-> filt_code_o == 6'h00)
      else $error("bypass with nonzero filter code");
   clear_pulse_a: assert property (peak_clear_o |=> !peak_clear_o)
      else $error("peak clear longer than one cycle");
   clear_no_read_a: assert property (peak_clear_o |-> !serial_out_peak_clear_oe)
      else $error("peak clear during readback");
endmodule

bind fgscp_top fgscp_top_chk u_chk (
   .clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .frame_latch_enable,
   .serial_out_peak_clear_oe, .filt_code_o, .filt_bypass_o, .post_gain_o,
   .dc_loop_en_o, .pwr_mode_o, .peak_clear_o
);

// >>> sim/fgscp_host.sv
`timescale 1ns/1ps
module fgscp_host (
   input  wire clk,    // system clock
   input  wire pin_o,  // device readback level
   input  wire pin_oe, // device drive enable
   output reg  le,     // latch, frame while low
   output reg  sck,    // serial clock, idles low
   output reg  sdi,    // serial data
   output wire pin     // resolved shared pin
);
   reg hv = 1'b0;
   reg he = 1'b1;
   // nobody driving in a read frame: show the opposite of the last device level, else the host level
   assign pin = pin_oe ? pin_o : (he ? hv : ~pin_o);
   initial begin
      le = 1'b1;
      sck = 1'b0;
      sdi = 1'b0;
   end
   task automatic tick(input integer n);
      repeat (n) @(posedge clk);
   endtask
   // low half of 5 clk and high half of 9 keep each level past the pin synchronisers
   task automatic frame(input [14:0] w, input integer n, input logic wr,
                        output logic [14:0] r);
      integer i;
      r = 15'h0000;
      le <= 1'b0;
      tick(5);
      sdi <= wr;
      he <= wr;
      tick(5);
      sck <= 1'b1;
      for (i = 0; i < n; i = i + 1) begin
         tick(5);
         sck <= 1'b0;
         sdi <= (i < 15) ? w[i] : 1'b0;
         tick(5);
         sck <= 1'b1;
         tick(4);
         if (i < 15)
            r[i] = pin;
      end
      tick(5);
      le <= 1'b1;
      sck <= 1'b0;
      sdi <= ~sdi;
      he <= 1'b1;
      tick(12);
   endtask
   task automatic pulse(input integer n);
      hv <= 1'b1;
      tick(n);
      hv <= 1'b0;
   endtask
endmodule

// >>> sim/filter_gain_serial_config_port_bench.sv
`timescale 1ns/1ps
`include "fgscp_consts.vh"
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module filter_gain_serial_config_port_bench;
   reg         clk = 1'b0;
   reg         rstn = 1'b0;
   reg         cyc = 1'b0;
   reg         stb = 1'b0;
   reg         we = 1'b0;
   reg  [3:0]  adr = 4'h0;
   reg  [3:0]  sel = 4'h0;
   reg  [31:0] dw = 32'h0;
   reg  [31:0] rd;
   reg  [14:0] rb;
   reg  [14:0] tab [0:3] = '{15'h0000, 15'h3FFF, 15'h1541, 15'h2AAA};
   wire [31:0] dr;
   wire        ack, le, sck, sdi, pin, po, poe, byp, bufhi, dcl, pclr;
   wire [5:0]  filt;
   wire [1:0]  pre, post, pwr;
   integer     failures = 0;
   integer     n_tests = 0;
   integer     cyc_n = 0;
   integer     n_clr = 0;
   integer     i, k;
   always #5 clk = ~clk;
   fgscp_top uut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
      .frame_latch_enable(le), .serial_clk(sck), .serial_data(sdi),
      .serial_out_peak_clear_i(pin), .serial_out_peak_clear_o(po),
      .serial_out_peak_clear_oe(poe), .filt_code_o(filt), .filt_bypass_o(byp),
      .pre_gain_o(pre), .post_gain_o(post), .buf_gain_hi_o(bufhi), .dc_loop_en_o(dcl),
      .pwr_mode_o(pwr), .peak_clear_o(pclr));
   fgscp_host host (.clk(clk), .pin_o(po), .pin_oe(poe), .le(le), .sck(sck), .sdi(sdi),
      .pin(pin));
   task automatic test_done;
      if (failures == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests = n_tests + 1;
      if (g !== e) begin
         failures = failures + 1;
         $display("[FAIL] %s exp %0h got %0h", n, e, g);
      end
   endtask
   task automatic wb(input logic w, input [3:0] a, input [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      dw <= d;
      do @(posedge clk); while (ack !== 1'b1);
      rd = dr;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic chk_cfg(input [14:0] w);
      wb(1'b0, `FGSCP_ADR_CFG, 32'h0);
      `CHK("cfg", w, rd);
      `CHK("filt", w[5:0], filt);
      `CHK("bypass", w[5:0] == 6'h00, byp);
      `CHK("pre", w[7:6], pre);
      `CHK("post", w[9:8], post);
      `CHK("buf", w[10], bufhi);
      `CHK("dc loop", w[11], dcl);
      `CHK("power", w[13:12], pwr);
   endtask
   always @(posedge clk) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 20000) begin
         failures = failures + 1;
         test_done;
      end
   end
   // every clear of the run, so a stray one during a read is seen
   always @(posedge clk) begin
      if (pclr === 1'b1)
         n_clr <= n_clr + 1;
   end
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      chk_cfg(`FGSCP_CFG_RST);
      wb(1'b0, 4'hC, 32'h0);
      `CHK("unmapped", 0, rd);
      for (i = 0; i < 4; i = i + 1) begin
         host.frame(tab[i], 15, 1'b1, rb);
         chk_cfg(tab[i]);
         host.frame(15'h0000, 15, 1'b0, rb);
         `CHK("readback", tab[i], rb);
         chk_cfg(tab[i]);
      end
      // short and long writes must be thrown away whole
      host.frame(15'h7FFF, 8, 1'b1, rb);
      chk_cfg(tab[3]);
      host.frame(15'h7FFF, 16, 1'b1, rb);
      chk_cfg(tab[3]);
      wb(1'b1, `FGSCP_ADR_CTRL, 32'h0);
      wb(1'b0, `FGSCP_ADR_CTRL, 32'h0);
      `CHK("ctrl off", 0, rd);
      host.frame(15'h0155, 15, 1'b1, rb);
      chk_cfg(tab[3]);
      wb(1'b0, `FGSCP_ADR_STAT, 32'h0);
      `CHK("stat", 32'h0402040C, rd);
      wb(1'b1, `FGSCP_ADR_CTRL, 32'h3);
      k = 0;
      repeat (10) @(posedge clk) k = k + pclr;
      `CHK("sw clear", 1, k);
      wb(1'b0, `FGSCP_ADR_CTRL, 32'h0);
      `CHK("ctrl on", 1, rd);
      k = 0;
      fork
         host.pulse(5);
         repeat (20) @(posedge clk) k = k + pclr;
      join
      `CHK("peak clear", 1, k);
      `CHK("clear total", 2, n_clr);
      test_done;
   end
endmodule
